// ### core/irpe_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module irpe_fifo
   import irpe_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign o_in_ready  = (count != DEPTH[AW:0]);
   assign o_out_valid = (count != '0);
   assign o_out_data  = mem[rd_ptr];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = i_out_ready && o_out_valid;

   always_comb begin
      next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count  = count;
      if (push && !pop) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (i_ce) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_ce && push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end
endmodule

// ### core/irpe_pkg.sv
// constants, types and overview for the infrared pulse encoder/decoder
// Overview of operation
// R01 - crystal clock divided by 2,4,12,24,6,48,96 per the three rate-select inputs
// R02 - encode and decode timed by a 16x baud tick; one bit is 16 ticks
// R03 - one optical pulse is emitted for every space bit on serial transmit input
// R04 - a mark bit leaves the optical output low with no pulse
// R05 - after transmit falling edge wait 7 ticks, drive high 3 ticks, then low
// R06 - consecutive space bits give pulses one bit time apart
// R07 - every falling edge on optical receive input is one received pulse; the code drops edges that arrive while its 8-entry receive queue is full
// R08 - each received pulse drives serial receive output low for 16 ticks
// R09 - uart should hold transmit input high while idle
// R10 - while oscillator sleep is high nothing is sent or received
// R11 - monoshot mode: each modulation rising edge gives 6 crystal cycles high
// R12 - monoshot pulse length is fixed whatever the rate-select code
// R13 - clock select high uses external 16x clock and stops the oscillator
// R14 - oneshot mode input high selects monoshot transmit mode
// R15 - monoshot mode only with the crystal clock, never with external clock; monoshot is not gated by clock select here
// R16 - active-low state reset returns encode and decode machine to idle
// R17 - divided crystal clock is the internal 16x tick when selected
// R18 - rate code 111 is undefined; handled as divide by 2
package irpe_pkg;
   localparam logic [6:0] DIV_RATE_000  = 7'h02;
   localparam logic [6:0] DIV_RATE_001  = 7'h04;
   localparam logic [6:0] DIV_RATE_010  = 7'h0c;
   localparam logic [6:0] DIV_RATE_011  = 7'h18;
   localparam logic [6:0] DIV_RATE_100  = 7'h06;
   localparam logic [6:0] DIV_RATE_101  = 7'h30;
   localparam logic [6:0] DIV_RATE_110  = 7'h60;
   localparam logic [6:0] DIV_RESET     = 7'h00;
   localparam logic [3:0] ENC_PULSE_LO  = 4'h7;
   localparam logic [3:0] ENC_PULSE_HI  = 4'h9;
   localparam logic [3:0] BIT_LAST_TICK = 4'hf;
   localparam logic [3:0] CNT_RESET     = 4'h0;
   localparam logic [2:0] MONO_CYCLES   = 3'h6;
   localparam logic [2:0] MONO_RESET    = 3'h0;
   localparam int         FIFO_WIDTH    = 1;
   localparam int         FIFO_DEPTH    = 8;

   typedef struct packed {
      logic       tx;
      logic       rx;
      logic       ext_clk;
      logic       clk_sel;
      logic       mono;
      logic       sleep;
      logic       rst_n;
      logic [2:0] rate;
   } irpe_pins_s;

   localparam irpe_pins_s PINS_RESET = '{tx: 1'b1, rx: 1'b1, ext_clk: 1'b0,
      clk_sel: 1'b0, mono: 1'b0, sleep: 1'b0, rst_n: 1'b1, rate: 3'h0};

   typedef enum logic {ENC_IDLE, ENC_SLOT} irpe_enc_e;
endpackage

// ### core/irpe_top.sv
// infrared pulse encoder/decoder core
`timescale 1ns/10ps
module irpe_top
   import irpe_pkg::*;
(
   input  wire logic I_CORE_CLK,
   input  wire logic I_RST,
   input  wire logic I_CE,
   input  wire logic I_TX_SERIAL,
   output logic      O_RX_SERIAL,
   input  wire logic I_OPTICAL_RX_IN,
   output logic      O_OPTICAL_TX_OUT,
   input  wire logic I_RATE_SEL_BIT0,
   input  wire logic I_RATE_SEL_BIT1,
   input  wire logic I_RATE_SEL_BIT2,
   input  wire logic I_CLK_SEL,
   input  wire logic I_ONESHOT_MODE_IN,
   input  wire logic I_OSC_SLEEP_IN,
   input  wire logic I_STATE_RESET_N,
   input  wire logic I_BAUD_X16_CLOCK
);
   irpe_pins_s pins_raw;
   irpe_pins_s pins_meta;
   irpe_pins_s pins;
   irpe_pins_s pins_prev;
   logic       state_rst;
   logic       active;
   logic       tick;
   logic       ext_rise;
   logic       div_hit;
   logic [6:0] divisor;
   logic [6:0] div_cnt;
   logic [6:0] next_div_cnt;
   irpe_enc_e  enc_state;
   irpe_enc_e  next_enc_state;
   logic [3:0] enc_cnt;
   logic [3:0] next_enc_cnt;
   logic       enc_busy;
   logic       enc_high;
   logic       next_enc_high;
   logic       tx_fall;
   logic [2:0] mono_cnt;
   logic [2:0] next_mono_cnt;
   logic       mono_start;
   logic       tx_out;
   logic       next_tx_out;
   logic       rx_fall;
   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic       fifo_pop;
   logic       str_busy;
   logic       next_str_busy;
   logic [3:0] str_cnt;
   logic [3:0] next_str_cnt;
   logic       rx_out;
   logic       next_rx_out;

   // two-stage capture of every pin
   always_comb begin
      pins_raw.tx      = I_TX_SERIAL;
      pins_raw.rx      = I_OPTICAL_RX_IN;
      pins_raw.ext_clk = I_BAUD_X16_CLOCK;
      pins_raw.clk_sel = I_CLK_SEL;
      pins_raw.mono    = I_ONESHOT_MODE_IN;
      pins_raw.sleep   = I_OSC_SLEEP_IN;
      pins_raw.rst_n   = I_STATE_RESET_N;
      pins_raw.rate    = {I_RATE_SEL_BIT2, I_RATE_SEL_BIT1, I_RATE_SEL_BIT0};
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         pins_meta <= PINS_RESET;
         pins      <= PINS_RESET;
         pins_prev <= PINS_RESET;
      end else if (I_CE) begin
         pins_meta <= pins_raw;
         pins      <= pins_meta;
         pins_prev <= pins;
      end
   end

   assign state_rst = I_RST || !pins.rst_n;  // [R16]
   assign active    = !pins.sleep;           // [R10]

   // tick source: external 16x clock or divided crystal
   always_comb begin
      case (pins.rate)  // [R01]
         3'h0:    divisor = DIV_RATE_000;
         3'h1:    divisor = DIV_RATE_001;
         3'h2:    divisor = DIV_RATE_010;
         3'h3:    divisor = DIV_RATE_011;
         3'h4:    divisor = DIV_RATE_100;
         3'h5:    divisor = DIV_RATE_101;
         3'h6:    divisor = DIV_RATE_110;
         default: divisor = DIV_RATE_000;  // [R18]
      endcase
   end

   assign ext_rise = pins.ext_clk && !pins_prev.ext_clk;
   assign div_hit  = (div_cnt == 7'(divisor - 1'b1));
   // oscillator stops when external clock or sleep is selected
   assign tick     = active && (pins.clk_sel ? ext_rise : div_hit);  // [R13] [R17] [R02]

   always_comb begin
      next_div_cnt = div_cnt;
      if (pins.clk_sel || pins.sleep) begin
         next_div_cnt = DIV_RESET;  // [R13]
      end else if (div_hit || div_cnt >= divisor) begin
         next_div_cnt = DIV_RESET;
      end else begin
         next_div_cnt = 7'(div_cnt + 1'b1);
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         div_cnt <= DIV_RESET;
      end else if (I_CE) begin
         div_cnt <= next_div_cnt;
      end
   end

   // encoder: one bit slot of 16 ticks per space bit
   assign tx_fall  = !pins.tx && pins_prev.tx;
   assign enc_busy = (enc_state == ENC_SLOT);

   always_comb begin
      next_enc_state = enc_state;
      next_enc_cnt   = enc_cnt;
      case (enc_state)
         ENC_IDLE: begin
            if (tx_fall && active) begin  // [R03]
               next_enc_state = ENC_SLOT;
               next_enc_cnt   = CNT_RESET;
            end
         end
         ENC_SLOT: begin
            if (!active) begin
               next_enc_state = ENC_IDLE;  // [R10]
               next_enc_cnt   = CNT_RESET;
            end else if (tick) begin
               next_enc_cnt = 4'(enc_cnt + 1'b1);
               if (enc_cnt == BIT_LAST_TICK) begin
                  next_enc_state = pins.tx ? ENC_IDLE : ENC_SLOT;  // [R06] [R04]
               end
            end
         end
         default: begin
            next_enc_state = ENC_IDLE;
            next_enc_cnt   = CNT_RESET;
         end
      endcase
      // high from tick 7 through tick 9 of the slot
      next_enc_high = (next_enc_state == ENC_SLOT) && (next_enc_cnt >= ENC_PULSE_LO)
                      && (next_enc_cnt <= ENC_PULSE_HI);  // [R05]
   end

   // monoshot stretches each modulation rising edge to 6 crystal cycles
   assign mono_start = pins.mono && next_enc_high && !enc_high;  // [R14] [R15]

   always_comb begin
      next_mono_cnt = mono_cnt;
      if (mono_start) begin
         next_mono_cnt = MONO_CYCLES;  // [R11] [R12]
      end else if (mono_cnt != MONO_RESET) begin
         next_mono_cnt = 3'(mono_cnt - 1'b1);
      end
      next_tx_out = pins.mono ? (next_mono_cnt != MONO_RESET) : next_enc_high;  // [R04]
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (state_rst) begin
         enc_state <= ENC_IDLE;
         enc_cnt   <= CNT_RESET;
         enc_high  <= 1'b0;
         mono_cnt  <= MONO_RESET;
         tx_out    <= 1'b0;
      end else if (I_CE) begin
         enc_state <= next_enc_state;
         enc_cnt   <= next_enc_cnt;
         enc_high  <= next_enc_high;
         mono_cnt  <= next_mono_cnt;
         tx_out    <= next_tx_out;
      end
   end

   assign O_OPTICAL_TX_OUT = tx_out;

   // decoder: received pulses queue up, each stretched to one bit
   assign rx_fall  = !pins.rx && pins_prev.rx && active;  // [R07]
   assign fifo_pop = !str_busy && fifo_out_valid && active;

   irpe_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk       (I_CORE_CLK),
      .i_rst       (state_rst),
      .i_ce        (I_CE),
      .i_in_valid  (rx_fall),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (1'b0),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_pop),
      .o_out_data  ()
   );

   always_comb begin
      next_str_busy = str_busy;
      next_str_cnt  = str_cnt;
      if (!active) begin
         next_str_busy = 1'b0;  // [R10]
         next_str_cnt  = CNT_RESET;
      end else if (fifo_pop) begin
         next_str_busy = 1'b1;
         next_str_cnt  = CNT_RESET;
      end else if (str_busy && tick) begin
         next_str_cnt = 4'(str_cnt + 1'b1);
         if (str_cnt == BIT_LAST_TICK) begin
            next_str_busy = 1'b0;  // [R08]
         end
      end
      next_rx_out = !next_str_busy;  // [R08]
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (state_rst) begin
         str_busy <= 1'b0;
         str_cnt  <= CNT_RESET;
         rx_out   <= 1'b1;
      end else if (I_CE) begin
         str_busy <= next_str_busy;
         str_cnt  <= next_str_cnt;
         rx_out   <= next_rx_out;
      end
   end

   assign O_RX_SERIAL = rx_out;

   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (state_rst || !I_CE);

   sequence s_mono_start;
      pins.mono && mono_start;
   endsequence
   sequence s_mono_pulse;
      O_OPTICAL_TX_OUT [*6] ##1 !O_OPTICAL_TX_OUT;
   endsequence
   property p_mono_len;
      s_mono_start |=> s_mono_pulse;
   endproperty
   a_mono_len: assert property (p_mono_len) else $error("monoshot length wrong"); // [R11] [R12]

   property p_enc_shape;
      (!pins.mono && enc_busy && enc_cnt >= 4'h7 && enc_cnt <= 4'h9) |-> O_OPTICAL_TX_OUT;
   endproperty
   a_enc_shape: assert property (p_enc_shape) else $error("pulse missing in slot"); // [R05]

   property p_enc_gap;
      (!pins.mono && (!enc_busy || enc_cnt < 4'h7 || enc_cnt > 4'h9)) |-> !O_OPTICAL_TX_OUT;
   endproperty
   a_enc_gap: assert property (p_enc_gap) else $error("optical out high outside pulse"); // [R04]

   property p_enc_start;
      (tx_fall && active && !enc_busy) |=> (enc_busy && enc_cnt == 4'h0);
   endproperty
   a_enc_start: assert property (p_enc_start) else $error("space bit not started"); // [R03]

   property p_enc_repeat;
      (enc_busy && tick && enc_cnt == 4'hf && !pins.tx) |=> (enc_busy && enc_cnt == 4'h0);
   endproperty
   a_enc_repeat: assert property (p_enc_repeat) else $error("next space slot lost"); // [R06]

   property p_dec_take;
      (rx_fall && fifo_in_ready && !fifo_pop && !str_busy) |=> ##1 !O_RX_SERIAL;
   endproperty
   a_dec_take: assert property (p_dec_take) else $error("received pulse not stretched"); // [R07]

   property p_stretch;
      (str_busy && str_cnt == 4'hf && tick && active) |=> O_RX_SERIAL;
   endproperty
   a_stretch: assert property (p_stretch) else $error("stretch end wrong"); // [R08]

   property p_sleep;
      pins.sleep |-> (!tick && !rx_fall);
   endproperty
   a_sleep: assert property (p_sleep) else $error("activity while asleep"); // [R10]

   property p_div;
      (!pins.clk_sel && active && div_cnt == 7'(divisor - 1'b1)) |-> tick;
   endproperty
   a_div: assert property (p_div) else $error("divided tick missing"); // [R01] [R17]

   property p_ext;
      (pins.clk_sel && active) |-> (tick == ext_rise) ##1 (div_cnt == 7'h00);
   endproperty
   a_ext: assert property (p_ext) else $error("external clock select wrong"); // [R13]
endmodule

// ### verif/irpe_top_tb.sv
// self-checking bench for the infrared pulse encoder/decoder
`timescale 1ns/10ps
module irpe_top_tb import irpe_pkg::*; ;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        tx = 1'b1;
   logic [2:0]  sel = 3'h0;
   logic        clk_sel = 1'b0;
   logic        mono = 1'b0;
   logic        sleep = 1'b0;
   logic        srst_n = 1'b1;
   logic        ce = 1'b1;
   logic [2:0]  ext_cnt = 3'h0;
   logic        send = 1'b0;
   logic        opt_rx;
   logic        rx_ser;
   logic        opt_tx;
   logic [15:0] p_cnt;
   logic [15:0] p_len;
   logic [15:0] p_gap;
   logic [15:0] rx_falls = 16'h0;
   logic [15:0] rx_len = 16'h0;
   logic [15:0] rx_run = 16'h0;
   logic        rx_prev = 1'b1;
   int          err_total = 0;
   int          samples_checked = 0;
   logic [6:0]  divs [8] = '{DIV_RATE_000, DIV_RATE_001, DIV_RATE_010, DIV_RATE_011,
                             DIV_RATE_100, DIV_RATE_101, DIV_RATE_110, DIV_RATE_000};

   always #20 clk = ~clk;

   irpe_top u_irpe_top (
      .I_CORE_CLK        (clk),
      .I_RST             (rst),
      .I_CE              (ce),
      .I_TX_SERIAL       (tx),
      .O_RX_SERIAL       (rx_ser),
      .I_OPTICAL_RX_IN   (opt_rx),
      .O_OPTICAL_TX_OUT  (opt_tx),
      .I_RATE_SEL_BIT0   (sel[0]),
      .I_RATE_SEL_BIT1   (sel[1]),
      .I_RATE_SEL_BIT2   (sel[2]),
      .I_CLK_SEL         (clk_sel),
      .I_ONESHOT_MODE_IN (mono),
      .I_OSC_SLEEP_IN    (sleep),
      .I_STATE_RESET_N   (srst_n),
      .I_BAUD_X16_CLOCK  (ext_cnt[2])
   );

   irpe_xcvr_model u_irpe_xcvr_model (
      .i_clk     (clk),
      .i_light   (opt_tx),
      .i_send    (send),
      .o_rx_line (opt_rx),
      .o_cnt     (p_cnt),
      .o_len     (p_len),
      .o_gap     (p_gap)
   );

   // serial receive monitor: falls and low length in core cycles
   always @(posedge clk) begin
      rx_run <= rx_ser ? 16'h0 : rx_run + 16'h1;
      if (!rx_ser && rx_prev)
         rx_falls <= rx_falls + 16'h1;
      if (rx_ser && !rx_prev)
         rx_len <= rx_run;
      rx_prev <= rx_ser;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // external 16x clock, period 8 core cycles
   always begin
      cyc(1);
      ext_cnt = ext_cnt + 3'h1;
   end

   task automatic chk(input string nm, input int lo, input int hi, input logic [15:0] got);
      samples_checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, got);
         err_total++;
      end
   endtask

   task automatic pulse();
      send = 1'b1;
      cyc(1);
      send = 1'b0;
   endtask

   task automatic space(input int nb, input int d);
      tx = 1'b0;
      cyc(16 * d * nb - 8 * d);
      tx = 1'b1;
   endtask

   task automatic enc_one(input int d, input int len_exp);
      int          n;
      logic [15:0] c0;
      c0 = p_cnt;
      n = 0;
      tx = 1'b0;
      while (opt_tx !== 1'b1 && n < 4000) begin
         cyc(1);
         n++;
      end
      chk("rise_delay", 6 * d + 2, 7 * d + 5, n[15:0]);
      cyc(6 * d);
      tx = 1'b1;
      cyc(32 * d);
      chk("pulse_len", len_exp, len_exp, p_len);
      chk("pulse_cnt", c0 + 1, c0 + 1, p_cnt);
   endtask

   task report_and_stop();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      report_and_stop();
   end

   initial begin
      logic [15:0] c0;
      logic [15:0] f0;
      cyc(20);
      rst = 1'b0;
      cyc(5);
      chk("idle_tx", 0, 0, {15'h0, opt_tx});
      chk("idle_rx", 1, 1, {15'h0, rx_ser});
      for (int c = 0; c < 8; c++) begin
         sel = c[2:0];
         cyc(200);
         enc_one(int'(divs[c]), 3 * int'(divs[c]));
      end
      sel = 3'h1;
      cyc(200);
      c0 = p_cnt;
      space(3, 4);
      cyc(128);
      chk("burst_cnt", c0 + 3, c0 + 3, p_cnt);
      chk("burst_gap", 64, 64, p_gap);
      c0 = p_cnt;
      cyc(200);
      chk("mark_cnt", c0, c0, p_cnt);
      sel = 3'h3;
      cyc(200);
      f0 = rx_falls;
      pulse();
      cyc(420);
      chk("rx_falls", f0 + 1, f0 + 1, rx_falls);
      chk("rx_len", 15 * 24 + 1, 16 * 24, rx_len);
      sel = 3'h0;
      cyc(200);
      f0 = rx_falls;
      for (int i = 0; i < 12; i++) begin
         pulse();
         cyc(4);
      end
      cyc(400);
      chk("rx_fifo", f0 + 10, f0 + 10, rx_falls);
      pulse();
      cyc(10);
      ce = 1'b0;
      cyc(100);
      ce = 1'b1;
      cyc(60);
      chk("ce_hold", 15 * 2 + 101, 16 * 2 + 100, rx_len);
      sleep = 1'b1;
      cyc(5);
      c0 = p_cnt;
      f0 = rx_falls;
      tx = 1'b0;
      pulse();
      cyc(100);
      tx = 1'b1;
      chk("sleep_tx", c0, c0, p_cnt);
      chk("sleep_rx", f0, f0, rx_falls);
      sleep = 1'b0;
      cyc(100);
      clk_sel = 1'b1;
      sel = 3'h6;
      cyc(50);
      enc_one(8, 24);
      clk_sel = 1'b0;
      mono = 1'b1;
      cyc(200);
      enc_one(96, 6);
      sel = 3'h0;
      cyc(200);
      enc_one(2, 6);
      mono = 1'b0;
      sel = 3'h2;
      cyc(200);
      c0 = p_cnt;
      f0 = rx_falls;
      tx = 1'b0;
      pulse();
      cyc(96);
      srst_n = 1'b0;
      cyc(5);
      chk("srst_tx", 0, 0, {15'h0, opt_tx});
      chk("srst_rx", 1, 1, {15'h0, rx_ser});
      tx = 1'b1;
      srst_n = 1'b1;
      cyc(480);
      chk("srst_cnt", c0 + 1, c0 + 1, p_cnt);
      chk("srst_falls", f0 + 1, f0 + 1, rx_falls);
      report_and_stop();
   end
endmodule

// ### verif/irpe_xcvr_model.sv
// infrared transceiver model: pulse source and emitter monitor
`timescale 1ns/10ps
module irpe_xcvr_model (
   input  wire logic        i_clk,
   input  wire logic        i_light,
   input  wire logic        i_send,
   output logic             o_rx_line,
   output logic [15:0]      o_cnt,
   output logic [15:0]      o_len,
   output logic [15:0]      o_gap
);
   logic [1:0]  low_left = 2'h0;
   logic        prev = 1'b0;
   logic [15:0] run = 16'h0;
   logic [15:0] since = 16'h0;

   initial begin
      o_cnt = 16'h0;
      o_len = 16'h0;
      o_gap = 16'h0;
   end

   // receiver idles high, a send request pulls it low for 3 cycles
   assign o_rx_line = (low_left == 2'h0);

   always @(posedge i_clk) begin
      if (i_send && low_left == 2'h0)
         low_left <= 2'h3;
      else if (low_left != 2'h0)
         low_left <= low_left - 2'h1;
      if (i_light && !prev) begin
         o_cnt <= o_cnt + 16'h1;
         o_gap <= since;
         since <= 16'h1;
      end else begin
         since <= since + 16'h1;
      end
      run <= i_light ? run + 16'h1 : 16'h0;
      if (!i_light && prev)
         o_len <= run;
      prev <= i_light;
   end
endmodule
